// ---- inc/fbod_pkg.sv ----
// Shared constants and types for the flash bus operation decoder
package fbod_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int ADDR_W = 22;               // Word address width
  localparam int DATA_W = 16;               // Data word width
  // ****************************************
  // Command words
  // ****************************************
  localparam logic [15:0] CMD_SYNC_MODE  = 16'h00C5; // Enter burst reads
  localparam logic [15:0] CMD_ASYNC_MODE = 16'h00F0; // Back to async reads
  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [1:0] LINK_HALF = 2'h2;  // System cycles per half link clock
  localparam logic [7:0] READ_WAIT = 8'h03; // Link periods before async sample
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    OP_RD_LATCH, OP_RD_STEADY, OP_WRITE, OP_BURST
  } fbod_op_t;                              // Host operations
  typedef enum logic {ST_RD_ASYNC, ST_RD_SYNC} fbod_mode_t; // Read mode
  typedef enum logic {H_IDLE, H_BUSY} fbod_hst_t;          // Host sequencer
endpackage

// ---- inc/fbod_if.sv ----
// Flash pin bundle between host controller and flash device
`timescale 1ns/1ps
interface fbod_if;
  import fbod_pkg::*;
  logic              lclk;              // Burst clock, made by host
  logic              ce_n;              // Chip select
  logic              oe_n;              // Output enable
  logic              we_n;              // Write enable
  logic              address_valid_strobe_n; // Address strobe
  logic              reset_pin_n;       // Hardware reset pin
  logic [ADDR_W-1:0] word_address_bus;  // Address pins
  logic [DATA_W-1:0] dq_h;              // Host data out
  logic              dq_h_oe;           // Host drives data
  logic [DATA_W-1:0] dq_d;              // Device data out
  logic              dq_d_oe;           // Device drives data
  logic              rdy;               // Burst data valid
  logic [DATA_W-1:0] data_word_bus;     // Resolved data pins
  // Resolve the shared data pins; undriven bus reads as all ones
  assign data_word_bus = dq_h_oe ? dq_h : (dq_d_oe ? dq_d : 16'hFFFF);
  modport host (output lclk, ce_n, oe_n, we_n, address_valid_strobe_n,
                reset_pin_n, word_address_bus, dq_h, dq_h_oe,
                input dq_d, dq_d_oe, rdy, data_word_bus);
  modport device (input lclk, ce_n, oe_n, we_n, address_valid_strobe_n,
                  reset_pin_n, word_address_bus, dq_h, dq_h_oe,
                  data_word_bus, output dq_d, dq_d_oe, rdy);
endinterface

// ---- hdl/fbod_sync.sv ----
// Two flip-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module fbod_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;                 // First stage, read by q only
  // ****************************************
  // Two stages
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

// ---- hdl/fbod_device.sv ----
// Flash device end: decodes bus operations into reads and command latches
`timescale 1ns/1ps
module fbod_device
  import fbod_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  NRST,
  input  wire logic                  CLK_EN,
  fbod_if.device                     LINK,
  output logic [fbod_pkg::ADDR_W-1:0] ARR_ADDR,
  input  wire logic [fbod_pkg::DATA_W-1:0] ARR_DATA,
  output logic                       CMD_VALID,
  output logic [fbod_pkg::ADDR_W-1:0] CMD_ADDR,
  output logic [fbod_pkg::DATA_W-1:0] CMD_DATA,
  output logic                       MODE_SYNC
);
  import fbod_pkg::*;

  // ****************************************
  // Link-side state
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;            // Read address counter
    logic [DATA_W-1:0] dq;              // Output data word
    logic              dq_oe;           // Driving data pins
    logic              valid;           // Data word is valid
    logic              rdy;             // Ready pin
    logic              burst;           // Burst in progress
    logic              req;             // Command handed over toggle
    logic [ADDR_W-1:0] cmd_addr;        // Command address latch
    logic [DATA_W-1:0] cmd_data;        // Command data latch
  } fbod_link_t;

  // ****************************************
  // System-side state
  // ****************************************
  typedef struct packed {
    fbod_mode_t        mode;            // Internal state machine
    logic              ack;             // Command taken toggle
    logic              cmd_valid;       // New command pulse
    logic [ADDR_W-1:0] cmd_addr;        // Command address out
    logic [DATA_W-1:0] cmd_data;        // Command data out
  } fbod_sys_t;

  fbod_link_t lnk_r;                    // Link registers
  fbod_link_t lnk_nxt;                  // Link next value
  fbod_sys_t  sys_r;                    // System registers
  fbod_sys_t  sys_nxt;                  // System next value
  logic       link_rst_n;               // Pin or system reset
  logic [1:0] to_link;                  // Mode and ack, link side
  logic [1:0] to_sys;                   // Req and reset pin, sys side
  logic       busy;                     // Previous command not taken
  logic       sync_l;                   // Burst mode, link side
  logic       ack_l;                    // Ack toggle, link side
  logic       req_s;                    // Req toggle, system side
  logic       rpin_s;                   // Reset pin level, system side

  // Reset pin acts without the clock
  assign link_rst_n = LINK.reset_pin_n & NRST;
  assign sync_l     = to_link[1];
  assign ack_l      = to_link[0];
  assign req_s      = to_sys[1];
  assign rpin_s     = to_sys[0];
  assign busy       = lnk_r.req != ack_l;

  // ****************************************
  // Crossings
  // ****************************************
  // Mode level and ack toggle into the link clock
  fbod_sync #(.W(2)) u_to_link (
    .clk   (LINK.lclk),
    .rst_n (link_rst_n),
    .d     ({sys_r.mode == ST_RD_SYNC, sys_r.ack}),
    .q     (to_link)
  );
  // Req toggle and reset pin level into the system clock
  fbod_sync #(.W(2)) u_to_sys (
    .clk   (CLK_SYS),
    .rst_n (NRST),
    .d     ({lnk_r.req, LINK.reset_pin_n}),
    .q     (to_sys)
  );

  // ****************************************
  // Link decode
  // ****************************************
  // Pins are sampled on the rising link edge
  always_comb begin
    lnk_nxt = lnk_r;
    if (LINK.ce_n) begin
      // Standby ends any burst
      lnk_nxt.burst = 1'b0;
      lnk_nxt.valid = 1'b0;
    end else if (!LINK.we_n && LINK.oe_n) begin
      // Command write into holding latches, never the array
      if (!busy) begin
        lnk_nxt.cmd_addr = LINK.word_address_bus;
        lnk_nxt.cmd_data = LINK.data_word_bus;
        lnk_nxt.req      = ~lnk_r.req;
      end
      lnk_nxt.burst = 1'b0;
      lnk_nxt.valid = 1'b0;
    end else if (LINK.we_n && !LINK.address_valid_strobe_n) begin
      // Strobe low: take address, restart any burst
      lnk_nxt.addr = LINK.word_address_bus;
      if (sync_l) begin
        lnk_nxt.burst = 1'b1;
        lnk_nxt.valid = 1'b0;
      end else begin
        // Async: word for the held address follows
        lnk_nxt.burst = 1'b0;
        lnk_nxt.dq    = ARR_DATA;
        lnk_nxt.valid = lnk_r.valid | (lnk_r.addr == lnk_nxt.addr);
      end
    end else if (LINK.we_n) begin
      // Strobe high: address pins ignored
      if (lnk_r.burst) begin
        if (!LINK.oe_n) begin
          // Drive word, move counter to next address
          lnk_nxt.dq    = ARR_DATA;
          lnk_nxt.addr  = lnk_r.addr + 1'b1;
          lnk_nxt.valid = 1'b1;
        end
      end else begin
        // Async latched read, clock edges add nothing
        lnk_nxt.dq    = ARR_DATA;
        lnk_nxt.valid = 1'b1;
      end
    end
    // Ready marks a valid word while chip select is low
    lnk_nxt.rdy   = lnk_nxt.valid & ~LINK.ce_n;
    // Drive only while selected and reading
    lnk_nxt.dq_oe = lnk_nxt.valid & ~LINK.ce_n & ~LINK.oe_n
                    & LINK.we_n;
  end

  // ****************************************
  // Link registers
  // ****************************************
  // Reset pin clears everything, data pins float
  always_ff @(posedge LINK.lclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      lnk_r <= '0;
    end else begin
      lnk_r <= lnk_nxt;
    end
  end

  // ****************************************
  // Internal state machine
  // ****************************************
  // Takes each command once, picks the read mode
  always_comb begin
    sys_nxt           = sys_r;
    sys_nxt.cmd_valid = 1'b0;
    if (!rpin_s) begin
      // Reset pin: async reads, nothing pending
      sys_nxt.mode = ST_RD_ASYNC;
      sys_nxt.ack  = 1'b0;
    end else if (req_s != sys_r.ack) begin
      // Latches are stable until ack returns
      sys_nxt.ack       = req_s;
      sys_nxt.cmd_valid = 1'b1;
      sys_nxt.cmd_addr  = lnk_r.cmd_addr;
      sys_nxt.cmd_data  = lnk_r.cmd_data;
      unique case (sys_r.mode)
        ST_RD_ASYNC: begin
          if (lnk_r.cmd_data == CMD_SYNC_MODE) begin
            sys_nxt.mode = ST_RD_SYNC;
          end
        end
        ST_RD_SYNC: begin
          if (lnk_r.cmd_data == CMD_ASYNC_MODE) begin
            sys_nxt.mode = ST_RD_ASYNC;
          end
        end
      endcase
    end
  end

  // ****************************************
  // System registers
  // ****************************************
  // Power-up starts in async read mode
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      sys_r <= '0;
    end else if (CLK_EN) begin
      sys_r <= sys_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign LINK.dq_d    = lnk_r.dq;
  assign LINK.dq_d_oe = lnk_r.dq_oe;
  assign LINK.rdy     = lnk_r.rdy;
  assign ARR_ADDR     = lnk_r.addr;
  assign CMD_VALID    = sys_r.cmd_valid;
  assign CMD_ADDR     = sys_r.cmd_addr;
  assign CMD_DATA     = sys_r.cmd_data;
  assign MODE_SYNC    = sys_r.mode == ST_RD_SYNC;
endmodule

// ---- hdl/fbod_host.sv ----
// Host end: drives flash bus operations and makes the burst clock
`timescale 1ns/1ps
module fbod_host
  import fbod_pkg::*;
(
  input  wire logic                       CLK_SYS,
  input  wire logic                       NRST,
  input  wire logic                       CLK_EN,
  fbod_if.host                            LINK,
  input  wire logic                       REQ_VALID,
  input  wire fbod_pkg::fbod_op_t         REQ_OP,
  input  wire logic [fbod_pkg::ADDR_W-1:0] REQ_ADDR,
  input  wire logic [fbod_pkg::DATA_W-1:0] REQ_DATA,
  input  wire logic [7:0]                 REQ_LEN,
  input  wire logic                       FLASH_RST,
  output logic                            REQ_READY,
  output logic                            RSP_VALID,
  output logic [fbod_pkg::DATA_W-1:0]     RSP_DATA
);
  import fbod_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [1:0]        div;             // Half period counter
    logic              lclk;            // Burst clock
    fbod_hst_t         st;              // Sequencer state
    fbod_op_t          op;              // Current operation
    logic [7:0]        step;            // Link periods into operation
    logic [7:0]        left;            // Burst words still wanted
    logic              ce_n;            // Chip select
    logic              oe_n;            // Output enable
    logic              we_n;            // Write enable
    logic              avd_n;           // Address strobe
    logic              rpin_n;          // Reset pin
    logic [ADDR_W-1:0] addr;            // Address pins
    logic [DATA_W-1:0] dq;              // Write data
    logic              dq_oe;           // Driving data pins
    logic              ready;           // Accepting requests
    logic              rsp;             // Word returned pulse
    logic [DATA_W-1:0] rdata;           // Returned word
    logic              done;            // Finished, release at next fall
  } fbod_host_t;

  fbod_host_t h_r;                      // Registers
  fbod_host_t h_nxt;                    // Next value
  logic [DATA_W:0] pins_s;              // Synced ready and data
  logic            rise;                // Link clock rises now
  logic            fall;                // Link clock falls now

  // Device pins belong to the link clock
  fbod_sync #(.W(DATA_W + 1)) u_pins (
    .clk   (CLK_SYS),
    .rst_n (NRST),
    .d     ({LINK.rdy, LINK.data_word_bus}),
    .q     (pins_s)
  );
  assign rise = (h_r.div == LINK_HALF - 2'h1) & ~h_r.lclk;
  assign fall = (h_r.div == LINK_HALF - 2'h1) & h_r.lclk;

  // ****************************************
  // Sequencer
  // ****************************************
  // Pins change on falls, samples on rises; a pin moved on a rise
  // would race the device, which samples on that very edge
  always_comb begin
    h_nxt        = h_r;
    h_nxt.rsp    = 1'b0;
    h_nxt.rpin_n = ~FLASH_RST;
    // Clock divider, rising edge is the active one
    h_nxt.div    = (h_r.div == LINK_HALF - 2'h1) ? 2'h0 : h_r.div + 2'h1;
    h_nxt.lclk   = (rise | fall) ? ~h_r.lclk : h_r.lclk;
    if (FLASH_RST) begin
      // Reset pin aborts the operation
      h_nxt.st    = H_IDLE;
      h_nxt.done  = 1'b0;
      h_nxt.ce_n  = 1'b1;
      h_nxt.oe_n  = 1'b1;
      h_nxt.we_n  = 1'b1;
      h_nxt.dq_oe = 1'b0;
      h_nxt.ready = 1'b0;
    end else begin
      unique case (h_r.st)
        H_IDLE: begin
          h_nxt.ready = 1'b1;
          if (REQ_VALID && h_r.ready && fall) begin
            h_nxt.st    = H_BUSY;
            h_nxt.ready = 1'b0;
            h_nxt.op    = REQ_OP;
            h_nxt.step  = 8'h00;
            h_nxt.done  = 1'b0;
            h_nxt.left  = REQ_LEN;
            h_nxt.addr  = REQ_ADDR;
            h_nxt.ce_n  = 1'b0;
            h_nxt.avd_n = 1'b0;
            // Write: output enable high, write enable low
            h_nxt.oe_n  = (REQ_OP == OP_WRITE) | (REQ_OP == OP_BURST);
            h_nxt.we_n  = REQ_OP != OP_WRITE;
            h_nxt.dq    = REQ_DATA;
            h_nxt.dq_oe = REQ_OP == OP_WRITE;
          end
        end
        H_BUSY: begin
          if (fall) begin
            h_nxt.step = h_r.step + 8'h01;
            // Steady reads keep the strobe low
            h_nxt.avd_n = h_r.op == OP_RD_STEADY ? 1'b0 : 1'b1;
            if (h_r.op == OP_BURST) begin
              h_nxt.oe_n = 1'b0;
              h_nxt.addr = '0;
            end
            if (h_r.op == OP_WRITE || h_r.done || h_r.step == 8'hFF) begin
              h_nxt.st = H_IDLE;
            end
          end
          if (rise && h_r.op != OP_WRITE && h_r.op != OP_BURST
              && h_r.step == READ_WAIT) begin
            // Async read word is settled by now
            h_nxt.rsp   = 1'b1;
            h_nxt.rdata = pins_s[DATA_W-1:0];
            h_nxt.done  = 1'b1;
          end
          if (rise && h_r.op == OP_BURST && pins_s[DATA_W]) begin
            // Ready high: take the burst word
            h_nxt.rsp   = 1'b1;
            h_nxt.rdata = pins_s[DATA_W-1:0];
            h_nxt.left  = h_r.left - 8'h01;
            h_nxt.done  = h_r.left <= 8'h01;
          end
          if (h_nxt.st == H_IDLE) begin
            // Chip select high ends the burst
            h_nxt.ce_n  = 1'b1;
            h_nxt.oe_n  = 1'b1;
            h_nxt.we_n  = 1'b1;
            h_nxt.avd_n = 1'b1;
            h_nxt.dq_oe = 1'b0;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      h_r        <= '0;
      h_r.ce_n   <= 1'b1;
      h_r.oe_n   <= 1'b1;
      h_r.we_n   <= 1'b1;
      h_r.avd_n  <= 1'b1;
    end else if (CLK_EN) begin
      h_r <= h_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign LINK.lclk                   = h_r.lclk;
  assign LINK.ce_n                   = h_r.ce_n;
  assign LINK.oe_n                   = h_r.oe_n;
  assign LINK.we_n                   = h_r.we_n;
  assign LINK.address_valid_strobe_n = h_r.avd_n;
  assign LINK.reset_pin_n            = h_r.rpin_n;
  assign LINK.word_address_bus       = h_r.addr;
  assign LINK.dq_h                   = h_r.dq;
  assign LINK.dq_h_oe                = h_r.dq_oe;
  assign REQ_READY                   = h_r.ready;
  assign RSP_VALID                   = h_r.rsp;
  assign RSP_DATA                    = h_r.rdata;
endmodule

// ---- verification/fbod_properties.sv ----
// Link-side properties of the flash pins between host and device ends
`timescale 1ns/1ps
module fbod_properties
  import fbod_pkg::*;
(
  input wire logic                        lclk,
  input wire logic                        ce_n,
  input wire logic                        oe_n,
  input wire logic                        we_n,
  input wire logic                        address_valid_strobe_n,
  input wire logic                        reset_pin_n,
  input wire logic [fbod_pkg::ADDR_W-1:0] word_address_bus,
  input wire logic [fbod_pkg::DATA_W-1:0] dq_d,
  input wire logic                        dq_d_oe,
  input wire logic                        rdy
);
  import fbod_pkg::*;
  // ****************************************
  // Link domain, reset pin disables
  // ****************************************
  default clocking cb @(posedge lclk);
  endclocking
  default disable iff (!reset_pin_n);
  // Bench array returns the low half of the address as the word;
  // the word for a loaded address shows one edge after the load edge
  a_read_word_next: assert property (
    (!ce_n && !oe_n && we_n && !address_valid_strobe_n)
    ##1 (!ce_n && !oe_n && we_n)
    |=> dq_d_oe && dq_d == $past(word_address_bus[15:0], 2))
    else $error("async read word not driven after address load");
  // Drive only after an edge that selected a read
  a_drive_needs_read: assert property (
    dq_d_oe |-> $past(!ce_n && !oe_n && we_n))
    else $error("data driven without a selected read");
  // Deselect releases the data pins
  a_standby_release: assert property (
    ce_n |=> !dq_d_oe)
    else $error("data still driven after chip select high");
  // Output enable high releases the data pins
  a_oe_release: assert property (
    oe_n |=> !dq_d_oe)
    else $error("data still driven after output enable high");
  // A write edge never makes the device drive
  a_write_no_drive: assert property (
    !we_n |=> !dq_d_oe)
    else $error("device drove data after a write edge");
  // Ready only follows a selected edge
  a_rdy_needs_select: assert property (
    rdy |-> $past(ce_n) == 1'b0)
    else $error("ready high without chip select");
  // Ready high only with a word on the pins
  a_rdy_with_data: assert property (
    rdy |-> dq_d_oe)
    else $error("ready high while data not driven");
  // Leaving reset finds the pins quiet
  a_reset_idle: assert property (
    $rose(reset_pin_n) |-> !dq_d_oe && !rdy)
    else $error("device not idle at reset release");
  // Burst traffic: ready on consecutive edges
  c_burst_word: cover property (rdy ##1 rdy);
endmodule

// ---- verification/flash_bus_operation_decoder_test.sv ----
// Bench joining host and device ends over the flash pins
`timescale 1ns/1ps
module flash_bus_operation_decoder_test;
  import fbod_pkg::*;
  // ****************************************
  // Stimulus and observation
  // ****************************************
  logic              clk_sys   = 1'b0;   // System clock
  logic              nrst      = 1'b0;   // System reset
  logic              req_valid = 1'b0;   // Host request
  fbod_op_t          req_op    = OP_RD_LATCH;
  logic [ADDR_W-1:0] req_addr  = '0;
  logic [DATA_W-1:0] req_data  = '0;
  logic [7:0]        req_len   = 8'h01;
  logic              flash_rst = 1'b0;   // Reset pin request
  logic              req_ready;
  logic              rsp_valid;
  logic [DATA_W-1:0] rsp_data;
  logic [ADDR_W-1:0] arr_addr;
  logic [DATA_W-1:0] arr_data;
  logic              cmd_valid;
  logic [ADDR_W-1:0] cmd_addr;
  logic [DATA_W-1:0] cmd_data;
  logic              mode_sync;
  logic [DATA_W-1:0] rsp_q[$];           // Collected read words
  int                errors = 0;
  int                n_compared = 0;
  int                cmd_count = 0;      // Command pulses seen
  fbod_if link_if ();
  // Array word is the address low half
  assign arr_data = arr_addr[15:0];
  // Clock
  always #2.5 clk_sys = ~clk_sys;
  // Collect responses and command pulses
  always @(posedge clk_sys) begin
    if (rsp_valid === 1'b1) rsp_q.push_back(rsp_data);
    if (cmd_valid === 1'b1) cmd_count++;
  end
  fbod_host fbod_host_inst (
    .CLK_SYS(clk_sys), .NRST(nrst), .CLK_EN(1'b1), .LINK(link_if),
    .REQ_VALID(req_valid), .REQ_OP(req_op), .REQ_ADDR(req_addr),
    .REQ_DATA(req_data), .REQ_LEN(req_len), .FLASH_RST(flash_rst),
    .REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data));
  fbod_device fbod_device_inst (
    .CLK_SYS(clk_sys), .NRST(nrst), .CLK_EN(1'b1), .LINK(link_if),
    .ARR_ADDR(arr_addr), .ARR_DATA(arr_data), .CMD_VALID(cmd_valid),
    .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .MODE_SYNC(mode_sync));
  fbod_properties fbod_properties_inst (
    .lclk(link_if.lclk), .ce_n(link_if.ce_n), .oe_n(link_if.oe_n),
    .we_n(link_if.we_n),
    .address_valid_strobe_n(link_if.address_valid_strobe_n),
    .reset_pin_n(link_if.reset_pin_n),
    .word_address_bus(link_if.word_address_bus), .dq_d(link_if.dq_d),
    .dq_d_oe(link_if.dq_d_oe), .rdy(link_if.rdy));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait for a level
  task automatic wait_level(ref logic sig, input logic val, input int lim);
    for (int i = 0; i < lim && sig !== val; i++) @(posedge clk_sys);
    if (sig !== val) begin
      errors++;
      $display("CHECK FAILED wait expected %b seen %b", val, sig);
      conclude();
    end
  endtask
  // One host operation, responses land in rsp_q
  task automatic run_op(fbod_op_t op, logic [ADDR_W-1:0] a,
                        logic [DATA_W-1:0] d, logic [7:0] n);
    rsp_q.delete();
    wait_level(req_ready, 1'b1, 400);
    req_valid <= 1'b1;
    req_op <= op;
    req_addr <= a;
    req_data <= d;
    req_len <= n;
    wait_level(req_ready, 1'b0, 400);
    req_valid <= 1'b0;
    wait_level(req_ready, 1'b1, 800);
    repeat (4) @(posedge clk_sys);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_write_cmd;
    int n0;
    n0 = cmd_count;
    run_op(OP_WRITE, 22'h012345, 16'hABCD, 8'h01);
    check("cmd count", n0 + 1, cmd_count);
    check("cmd addr", 22'h012345, cmd_addr);
    check("cmd data", 16'hABCD, cmd_data);
    check("mode", 1'b0, mode_sync);
    run_op(OP_RD_LATCH, 22'h012345, 16'h0000, 8'h01);
    check("array word", 16'h2345, rsp_q[0]);
    $display("test write_cmd done");
  endtask
  task automatic t_async_reads;
    logic [ADDR_W-1:0] tab[3] = '{22'h000000, 22'h2AA5A5, 22'h3FFFFF};
    for (int k = 0; k < 6; k++) begin
      run_op(k < 3 ? OP_RD_LATCH : OP_RD_STEADY, tab[k % 3], 16'h0000, 8'h01);
      check("read count", 1, rsp_q.size());
      check("read word", tab[k % 3] & 16'hFFFF, rsp_q[0]);
      check("standby", 1'b0, link_if.dq_d_oe);
    end
    $display("test async_reads done");
  endtask
  task automatic t_burst;
    run_op(OP_WRITE, 22'h000000, CMD_SYNC_MODE, 8'h01);
    check("sync mode", 1'b1, mode_sync);
    run_op(OP_BURST, 22'h000100, 16'h0000, 8'h05);
    check("burst count", 5, rsp_q.size());
    for (int i = 0; i < 5; i++) begin
      check("burst word", 16'h0100 + i, rsp_q[i]);
    end
    run_op(OP_BURST, 22'h3FFFFE, 16'h0000, 8'h04);
    check("burst count", 4, rsp_q.size());
    // Counter runs past the top address to zero, word is 16 bits
    for (int i = 0; i < 4; i++) begin
      check("wrap word", 16'(32'hFFFE + i), rsp_q[i]);
    end
    run_op(OP_WRITE, 22'h000000, CMD_ASYNC_MODE, 8'h01);
    check("async mode", 1'b0, mode_sync);
    $display("test burst done");
  endtask
  task automatic t_reset;
    run_op(OP_WRITE, 22'h000000, CMD_SYNC_MODE, 8'h01);
    check("sync mode", 1'b1, mode_sync);
    flash_rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("reset pin", 1'b0, link_if.reset_pin_n);
    check("reset drive", 1'b0, link_if.dq_d_oe);
    wait_level(mode_sync, 1'b0, 20);
    flash_rst <= 1'b0;
    repeat (16) @(posedge clk_sys);
    run_op(OP_RD_LATCH, 22'h00BEEF, 16'h0000, 8'h01);
    check("read after reset", 16'hBEEF, rsp_q[0]);
    $display("test reset done");
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_write_cmd();
    t_async_reads();
    t_burst();
    t_reset();
    conclude();
  end
endmodule
